// ### logic/adc_mode_pkg.sv
package adc_mode_pkg;

  // Register indices; each printed offset is an index, not a byte address
  localparam logic [3:0]  MAIN_CONFIGURATION_ADDR   = 4'h0;
  localparam logic [3:0]  I_CHANNEL_FULL_SCALE_ADDR = 4'h3;
  localparam logic [3:0]  Q_CHANNEL_FULL_SCALE_ADDR = 4'hb;

  // Field positions
  localparam int          INTERLEAVE_INPUT_SELECT_BIT = 6;

  // Reset values
  localparam logic [15:0] MAIN_CONFIGURATION_RST    = 16'h0000;
  localparam logic [15:0] FULL_SCALE_RST            = 16'h4000;

  // Range codes that the range-select pin maps onto
  localparam logic [15:0] FULL_SCALE_MID            = 16'h4000;
  localparam logic [15:0] FULL_SCALE_MIN            = 16'h0000;

  // Output clock divider width: output clock is the phase counter's top bit
  localparam int          DCLK_PHASE_W              = 2;

  // Pins, as seen at the device boundary
  typedef struct packed {
    logic extended_control_enable_pin_n; // Low selects register control
    logic coupling_select_pin_low;       // Pin reads low: AC coupling
    logic range_select_pin;              // High: mid full-scale setting
    logic dual_edge_pin;                 // High: dual-edge interleaved
    logic output_clock_reset;            // Positive pulse resets phase
    logic i_power_down;
    logic q_power_down;
    logic multi_chip_auto_alignment;
  } pins_s;

  // Conversion setup driven to the analog core
  typedef struct packed {
    logic        register_control_mode;
    logic        sample_rise_en;
    logic        sample_fall_en;
    logic        i_conv_from_q_side;   // 0: i_side_input, 1: q_side_input
    logic        q_conv_from_i_side;   // 1: q channel samples i_side_input
    logic        common_mode_bias_en;
    logic        offset_adjust_en;
    logic [15:0] i_full_scale;
    logic [15:0] q_full_scale;
  } conv_cfg_s;

endpackage

// ### logic/dual_adc_sampling_mode_control.sv
`timescale 1ns/10ps

// Behaviour
// - Non-interleaved: each input in own channel, rising
// - Interleaved, pin control: both channels sample I
// - Register interleaved: select bit picks Q input
// - DC coupling disables both inputs' bias
// - Pin control: one range for both channels
// - Register control: independent ranges from 3h, Bh
// - Pin high to mid, low to minimum
// - Offset adjust only under register control
// - Interleaved: sample both clock edges
// - Reset pulse zeroes both output clock phases
// - Output clocks share phase unless powered down
// - Reset pulse honoured during auto alignment
// - Enable pin low selects register control
// - Coupling pin low means AC coupling
module dual_adc_sampling_mode_control (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst_n,
  input  wire adc_mode_pkg::pins_s       i_pins,
  input  wire logic                      i_reg_wr_en,
  input  wire logic [3:0]                i_reg_addr,
  input  wire logic [15:0]               i_reg_wdata,
  output logic      [15:0]               o_reg_rdata,
  output adc_mode_pkg::conv_cfg_s        o_cfg,
  output logic                           o_i_output_clock,
  output logic                           o_q_output_clock
);
  import adc_mode_pkg::*;

  typedef struct packed {
    pins_s                    sync1;
    pins_s                    sync2;
    logic                     rst_prev;
    logic [DCLK_PHASE_W-1:0]  phase;
    logic [15:0]              main_cfg;
    logic [15:0]              i_fs;
    logic [15:0]              q_fs;
    logic [15:0]              rdata;
    conv_cfg_s                cfg;
    logic                     i_clk;
    logic                     q_clk;
  } state_s;

  state_s s_q;
  state_s s_d;

  function automatic logic [15:0] pin_range(input logic hi);
    pin_range = hi ? FULL_SCALE_MID : FULL_SCALE_MIN;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic reg_mode;
  logic dual_edge;
  logic rst_pulse;
  assign reg_mode  = ~s_q.sync2.extended_control_enable_pin_n;
  assign dual_edge = s_q.sync2.dual_edge_pin;
  // Edge taken from the second stage only; driver meets setup
  assign rst_pulse = s_q.sync2.output_clock_reset & ~s_q.rst_prev;

  always_comb begin
    s_d          = s_q;
    s_d.sync1    = i_pins;
    s_d.sync2    = s_q.sync1;
    s_d.rst_prev = s_q.sync2.output_clock_reset;

    // Writes are dropped under pin control; reads still return the registers
    if (i_reg_wr_en && reg_mode) begin
      unique case (i_reg_addr)
        MAIN_CONFIGURATION_ADDR:   s_d.main_cfg = i_reg_wdata;
        I_CHANNEL_FULL_SCALE_ADDR: s_d.i_fs     = i_reg_wdata;
        Q_CHANNEL_FULL_SCALE_ADDR: s_d.q_fs     = i_reg_wdata;
        default:                   s_d.rdata    = s_q.rdata;
      endcase
    end
    unique case (i_reg_addr)
      MAIN_CONFIGURATION_ADDR:   s_d.rdata = s_q.main_cfg;
      I_CHANNEL_FULL_SCALE_ADDR: s_d.rdata = s_q.i_fs;
      Q_CHANNEL_FULL_SCALE_ADDR: s_d.rdata = s_q.q_fs;
      default:                   s_d.rdata = 16'h0000;
    endcase

    s_d.cfg.register_control_mode = reg_mode;
    s_d.cfg.sample_rise_en        = 1'b1;
    s_d.cfg.sample_fall_en        = dual_edge;
    s_d.cfg.i_conv_from_q_side    = dual_edge && reg_mode
        && s_q.main_cfg[INTERLEAVE_INPUT_SELECT_BIT];
    // Non-interleaved keeps own input; interleaved pin mode uses I
    s_d.cfg.q_conv_from_i_side    = dual_edge
        && !s_d.cfg.i_conv_from_q_side;
    s_d.cfg.common_mode_bias_en   =
        s_q.sync2.coupling_select_pin_low;
    s_d.cfg.offset_adjust_en      = reg_mode;
    if (reg_mode) begin
      s_d.cfg.i_full_scale = s_q.i_fs;
      s_d.cfg.q_full_scale = s_q.q_fs;
    end else begin
      s_d.cfg.i_full_scale =
          pin_range(s_q.sync2.range_select_pin);
      s_d.cfg.q_full_scale = pin_range(s_q.sync2.range_select_pin);
    end

    // Auto alignment does not gate the pulse
    if (rst_pulse) begin
      s_d.phase = '0;
    end else begin
      s_d.phase = s_q.phase + 1'b1;
    end
    // One shared counter keeps both clocks in phase
    s_d.i_clk = s_d.phase[DCLK_PHASE_W-1] & ~s_q.sync2.i_power_down;
    s_d.q_clk = s_d.phase[DCLK_PHASE_W-1] & ~s_q.sync2.q_power_down;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q                              <= '0;
      s_q.sync1.extended_control_enable_pin_n <= 1'b1;
      s_q.sync2.extended_control_enable_pin_n <= 1'b1;
      s_q.main_cfg                     <= MAIN_CONFIGURATION_RST;
      s_q.i_fs                         <= FULL_SCALE_RST;
      s_q.q_fs                         <= FULL_SCALE_RST;
      s_q.cfg.sample_rise_en           <= 1'b1;
      s_q.cfg.i_full_scale             <= FULL_SCALE_MIN;
      s_q.cfg.q_full_scale             <= FULL_SCALE_MIN;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_reg_rdata      = s_q.rdata;
  assign o_cfg            = s_q.cfg;
  assign o_i_output_clock = s_q.i_clk;
  assign o_q_output_clock = s_q.q_clk;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence pin_mode_settled;
    s_q.sync2.extended_control_enable_pin_n [*2];
  endsequence

  sequence reg_mode_settled;
    !s_q.sync2.extended_control_enable_pin_n [*2];
  endsequence

  a_rise_always: assert property (o_cfg.sample_rise_en)
    else $error("rising edge sampling dropped");

  a_fall_edge: assert property (
    o_cfg.sample_fall_en == $past(s_q.sync2.dual_edge_pin))
    else $error("falling edge sampling not tracking mode");

  a_pin_interleave: assert property (
    (pin_mode_settled ##0 s_q.sync2.dual_edge_pin) |=>
      o_cfg.q_conv_from_i_side && !o_cfg.i_conv_from_q_side)
    else $error("pin interleave not on i input");

  a_q_select: assert property (
    (reg_mode_settled ##0 s_q.sync2.dual_edge_pin
      ##0 s_q.main_cfg[INTERLEAVE_INPUT_SELECT_BIT]) |=>
      o_cfg.i_conv_from_q_side && !o_cfg.q_conv_from_i_side)
    else $error("q input not selected");

  a_bias_coupling: assert property (
    ##1 o_cfg.common_mode_bias_en ==
      $past(s_q.sync2.coupling_select_pin_low))
    else $error("bias not following coupling pin");

  a_pin_range: assert property (
    (pin_mode_settled ##0 s_q.sync2.range_select_pin) |=>
      o_cfg.i_full_scale == FULL_SCALE_MID
      && o_cfg.q_full_scale == FULL_SCALE_MID)
    else $error("pin high range not mid");

  a_reg_range: assert property (
    reg_mode_settled |=> o_cfg.i_full_scale == $past(s_q.i_fs)
      && o_cfg.q_full_scale == $past(s_q.q_fs))
    else $error("register ranges not applied");

  a_offset_mode: assert property (
    pin_mode_settled |=> !o_cfg.offset_adjust_en)
    else $error("offset active under pin control");

  // A second legal pulse two cycles later restarts the phase again
  a_clk_reset: assert property (
    rst_pulse |=> !o_i_output_clock ##1 !o_i_output_clock
      ##1 (o_i_output_clock || $past(s_q.sync2.i_power_down)
        || $past(rst_pulse)))
    else $error("output clock phase not reset");

  a_q_clk_reset: assert property (
    rst_pulse |=> !o_q_output_clock ##1 !o_q_output_clock)
    else $error("q output clock phase not reset");

  a_clk_aligned: assert property (
    !s_q.sync2.i_power_down && !s_q.sync2.q_power_down |=>
      o_i_output_clock == o_q_output_clock)
    else $error("output clocks out of phase");

  // Power down parks the clock low so the far side sees no edges
  a_q_power_down: assert property (
    s_q.sync2.q_power_down |=> !o_q_output_clock)
    else $error("powered down clock still running");

  // Without interleave each channel keeps its own input
  a_own_inputs: assert property (
    !s_q.sync2.dual_edge_pin |=>
      !o_cfg.i_conv_from_q_side && !o_cfg.q_conv_from_i_side)
    else $error("channel not on its own input");

  a_pin_low_range: assert property (
    (pin_mode_settled ##0 !s_q.sync2.range_select_pin) |=>
      o_cfg.i_full_scale == FULL_SCALE_MIN
      && o_cfg.q_full_scale == FULL_SCALE_MIN)
    else $error("pin low range not minimum");

  a_pin_same_range: assert property (
    pin_mode_settled |=> o_cfg.i_full_scale == o_cfg.q_full_scale)
    else $error("pin ranges differ between channels");

  a_offset_reg: assert property (
    reg_mode_settled |=> o_cfg.offset_adjust_en)
    else $error("offset not offered under register control");

  // Mode lags the synchronised pin by the output flop only
  a_mode_pin: assert property (
    o_cfg.register_control_mode !=
      $past(s_q.sync2.extended_control_enable_pin_n))
    else $error("control mode not following enable pin");

endmodule

// ### bench/output_clock_reset_driver.sv
`timescale 1ns/10ps
module output_clock_reset_driver (
  input  wire logic i_ref_clk,
  output logic      o_output_clock_reset
);
  initial o_output_clock_reset = 1'b0;
  // Launched just after an edge and held whole cycles, so setup holds
  task automatic send(input int cycles);
    @(posedge i_ref_clk);
    #1 o_output_clock_reset = 1'b1;
    repeat (cycles) @(posedge i_ref_clk);
    #1 o_output_clock_reset = 1'b0;
  endtask
endmodule

// ### bench/dual_adc_sampling_mode_control_test.sv
`timescale 1ns/10ps
module dual_adc_sampling_mode_control_test;
  import adc_mode_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n   = 1'b0;
  pins_s       pins;
  pins_s       pins_in;
  logic        wr_en     = 1'b0;
  logic [3:0]  addr      = 4'h0;
  logic [15:0] wdata     = 16'h0000;
  logic [15:0] rdata;
  conv_cfg_s   cfg;
  logic        clk_i;
  logic        clk_q;
  logic        pulse;
  int          num_errors = 0;
  int          cmp_count  = 0;
  int          cycles     = 0;
  always #20 i_ref_clk = ~i_ref_clk;
  // Pulse comes from the partner, all other pins from the tests
  always_comb begin
    pins_in = pins;
    pins_in.output_clock_reset = pulse;
  end
  dual_adc_sampling_mode_control i_dut (
    .i_ref_clk       (i_ref_clk),
    .i_rst_n         (i_rst_n),
    .i_pins          (pins_in),
    .i_reg_wr_en     (wr_en),
    .i_reg_addr      (addr),
    .i_reg_wdata     (wdata),
    .o_reg_rdata     (rdata),
    .o_cfg           (cfg),
    .o_i_output_clock(clk_i),
    .o_q_output_clock(clk_q)
  );
  output_clock_reset_driver i_drv (
    .i_ref_clk           (i_ref_clk),
    .o_output_clock_reset(pulse)
  );
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic write(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    #1 wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge i_ref_clk);
    #1 wr_en = 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_ref_clk);
    #1 addr = a;
    @(posedge i_ref_clk);
    #1 check("rdata", rdata, exp);
  endtask
  // Pins cross a synchroniser, so allow four edges before looking
  task automatic set_pins(input pins_s p);
    @(posedge i_ref_clk);
    #1 pins = p;
    repeat (4) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    pins_s       p;
    int          n;
    logic [15:0] fs_exp;
    pins = 8'h80;
    repeat (12) @(posedge i_ref_clk);
    #1 i_rst_n = 1'b1;
    rd_chk(MAIN_CONFIGURATION_ADDR, MAIN_CONFIGURATION_RST);
    rd_chk(Q_CHANNEL_FULL_SCALE_ADDR, FULL_SCALE_RST);
    write(I_CHANNEL_FULL_SCALE_ADDR, 16'h1234);
    rd_chk(I_CHANNEL_FULL_SCALE_ADDR, FULL_SCALE_RST);
    p = pins;
    for (int k = 0; k < 4; k++) begin
      p.range_select_pin = k[0];
      p.dual_edge_pin = k[0];
      p.coupling_select_pin_low = k[1];
      set_pins(p);
      fs_exp = k[0] ? FULL_SCALE_MID : FULL_SCALE_MIN;
      check("i_fs", cfg.i_full_scale, fs_exp);
      check("q_fs", cfg.q_full_scale, fs_exp);
      check("bias", cfg.common_mode_bias_en, k[1]);
      check("fall", cfg.sample_fall_en, k[0]);
      check("rise", cfg.sample_rise_en, 1'b1);
      check("q_from_i", cfg.q_conv_from_i_side, k[0]);
      check("i_from_q", cfg.i_conv_from_q_side, 1'b0);
      check("offset", cfg.offset_adjust_en, 1'b0);
      check("mode", cfg.register_control_mode, 1'b0);
    end
    p.extended_control_enable_pin_n = 1'b0;
    set_pins(p);
    check("mode", cfg.register_control_mode, 1'b1);
    check("offset", cfg.offset_adjust_en, 1'b1);
    write(MAIN_CONFIGURATION_ADDR, 16'h0040);
    write(I_CHANNEL_FULL_SCALE_ADDR, 16'h1234);
    write(Q_CHANNEL_FULL_SCALE_ADDR, 16'h5678);
    write(4'h5, 16'hffff);
    rd_chk(4'h5, 16'h0000);
    rd_chk(MAIN_CONFIGURATION_ADDR, 16'h0040);
    check("i_fs", cfg.i_full_scale, 16'h1234);
    check("q_fs", cfg.q_full_scale, 16'h5678);
    check("i_from_q", cfg.i_conv_from_q_side, 1'b1);
    check("q_from_i", cfg.q_conv_from_i_side, 1'b0);
    write(MAIN_CONFIGURATION_ADDR, 16'h0000);
    repeat (2) @(posedge i_ref_clk);
    #1 check("i_from_q", cfg.i_conv_from_q_side, 1'b0);
    p.multi_chip_auto_alignment = 1'b1;
    set_pins(p);
    fork
      i_drv.send(2);
      for (int k = 1; k < 7; k++) begin
        @(posedge i_ref_clk);
        #2;
        if (k > 3) check("clk_i", clk_i, k > 5);
        if (k > 3) check("clk_q", clk_q, k > 5);
      end
    join
    p.q_power_down = 1'b1;
    set_pins(p);
    n = 0;
    repeat (4) begin
      @(posedge i_ref_clk);
      #1 check("clk_q", clk_q, 1'b0);
      n += clk_i;
    end
    check("i_highs", n[15:0], 16'h0002);
    give_verdict();
  end
endmodule
